// ==== rtl/pflt_top.sv ====
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
module pflt_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fault_input_a_n,
    input wire logic [5:0] duty_pins,
    input wire logic [2:0] pair_complementary,
    input wire logic [15:0] time_base_count,
    input wire logic count_down,
    input wire logic updown_mode,
    input wire logic cycle_boundary,
    input wire logic cpu_sleep,
    input wire logic cpu_idle,
    input wire logic buffer_load_req,
    output logic buffer_load,
    output logic pwm_run,
    output logic [5:0] pin_out,
    output logic trigger_out,
    output logic fault_irq,
    output logic wake_req
);
    logic [31:0] fault_control_reg_r;
    logic [31:0] second_control_reg_r;
    logic [31:0] trig_cmp_r;
    logic [31:0] time_base_control_r;
    logic [1:0] polarity_r;
    logic flag_r;
    logic active_r;
    logic [5:0] pin_r;
    logic buffer_load_r;
    logic run_r;
    logic trig_q;
    logic irq_r;
    logic wake_r;
    logic [31:0] rdata_r;
    logic fault_n_s;
    logic fault_n_d_r;
    logic flag_nxt;
    logic active_nxt;
    logic trig_ev;
    logic trig_post;

    pflt_pkg::pflt_fault_cfg_type cfg;
    assign cfg.pair_en = fault_control_reg_r[pflt_pkg::FC_EN_LSB +: 3];
    assign cfg.latch_mode = fault_control_reg_r[pflt_pkg::FC_MODE_BIT];
    assign cfg.ovr_state = fault_control_reg_r[pflt_pkg::FC_OVR_LSB +: 6];

    pflt_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(fault_input_a_n),
        .q(fault_n_s)
    );

    // APB decode
    wire logic setup_ok = psel && !penable;
    wire logic acc = psel && penable;
    wire logic wr = acc && pwrite;
    wire logic hit_fc = paddr == pflt_pkg::ADDR_FAULT_CTRL;
    wire logic hit_sc = paddr == pflt_pkg::ADDR_SECOND_CTRL;
    wire logic hit_tc = paddr == pflt_pkg::ADDR_TRIG_CMP;
    wire logic hit_tm = paddr == pflt_pkg::ADDR_TIME_CTRL;
    wire logic hit_st = paddr == pflt_pkg::ADDR_STATUS;
    wire logic hit_pl = paddr == pflt_pkg::ADDR_POLARITY;
    wire logic mapped = hit_fc | hit_sc | hit_tc | hit_tm | hit_st | hit_pl;
    // Writing 1 to the status flag bit clears it
    wire logic flag_clr = wr && hit_st && pwdata[pflt_pkg::ST_FLAG_BIT];

    function automatic logic [31:0] read_mux(input logic [11:0] a, input logic [31:0] st);
        case (a)
            pflt_pkg::ADDR_FAULT_CTRL: read_mux = {16'h0000, fault_control_reg_r[15:8], 1'b0,
                                                   fault_control_reg_r[7], 3'h0, fault_control_reg_r[2:0]};
            pflt_pkg::ADDR_SECOND_CTRL: read_mux = {20'h00000, second_control_reg_r[11:8], 7'h00,
                                                    second_control_reg_r[0]};
            pflt_pkg::ADDR_TRIG_CMP: read_mux = {16'h0000, trig_cmp_r[15:0]};
            pflt_pkg::ADDR_TIME_CTRL: read_mux = {18'h00000, time_base_control_r[13], 13'h0000};
            pflt_pkg::ADDR_STATUS: read_mux = st;
            pflt_pkg::ADDR_POLARITY: read_mux = {30'h00000000, polarity_r};
            default: read_mux = 32'h0000_0000;
        endcase
    endfunction

    wire logic [31:0] status_word = {29'h00000000, ~fault_n_s, active_r, flag_r};

    // Fault is seen only when the sync'd input is low
    wire logic fault_low = !fault_n_s;
    wire logic fault_fall = fault_n_d_r && !fault_n_s;
    // Flag works whether or not any pair is enabled
    assign flag_nxt = fault_fall ? 1'b1 : (flag_clr ? 1'b0 : flag_r);
    wire logic any_en = |cfg.pair_en;
    // Release condition differs by mode
    wire logic release_ok = cfg.latch_mode ? (!fault_low && !flag_nxt) : !fault_low;
    always_comb begin
        active_nxt = active_r;
        if (fault_low && any_en) begin
            active_nxt = 1'b1;
        end else if (active_r && release_ok && cycle_boundary) begin
            active_nxt = 1'b0;
        end
        if (!any_en) begin
            active_nxt = 1'b0;
        end
    end

    // Fault pin levels, high side bit at odd index
    logic [5:0] fault_lvl;
    logic [5:0] pin_nxt;
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_pair
            wire logic hi_act = cfg.ovr_state[2*g+1];
            // Complementary pair: high side wins
            wire logic lo_act = cfg.ovr_state[2*g] && !(pair_complementary[g] && hi_act);
            assign fault_lvl[2*g+1] = hi_act ~^ polarity_r[1];
            assign fault_lvl[2*g] = lo_act ~^ polarity_r[0];
            wire logic ovr = active_r && cfg.pair_en[g];
            assign pin_nxt[2*g+1] = ovr ? fault_lvl[2*g+1] : duty_pins[2*g+1];
            assign pin_nxt[2*g] = ovr ? fault_lvl[2*g] : duty_pins[2*g];
        end
    endgenerate

    // Idle halt
    wire logic run_nxt = !(cpu_idle && time_base_control_r[pflt_pkg::TM_IDLE_BIT]);

    // Trigger compare, direction only in up/down modes
    wire logic dir_ok = !updown_mode || (count_down == trig_cmp_r[pflt_pkg::TC_DIR_BIT]);
    assign trig_ev = run_r && (time_base_count == {1'b0, trig_cmp_r[14:0]}) && dir_ok;
    wire logic cmp_wr = wr && hit_tc;

    pflt_post u_post (
        .pclk(pclk),
        .presetn(presetn),
        .clear(cmp_wr),
        .event_in(trig_ev),
        .ratio(second_control_reg_r[pflt_pkg::SC_OPS_LSB +: 4]),
        .event_out(trig_post)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_control_reg_r <= pflt_pkg::FAULT_CTRL_RST;
            second_control_reg_r <= pflt_pkg::SECOND_CTRL_RST;
            trig_cmp_r <= pflt_pkg::TRIG_CMP_RST;
            time_base_control_r <= pflt_pkg::TIME_CTRL_RST;
            polarity_r <= pflt_pkg::POLARITY_RST;
        end else if (wr) begin
            if (hit_fc) fault_control_reg_r <= pwdata;
            if (hit_sc) second_control_reg_r <= pwdata;
            if (hit_tc) trig_cmp_r <= pwdata;
            if (hit_tm) time_base_control_r <= pwdata;
            if (hit_pl) polarity_r <= pwdata[1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_n_d_r <= 1'b1;
            flag_r <= 1'b0;
            active_r <= 1'b0;
            pin_r <= 6'h00;
            run_r <= 1'b1;
            buffer_load_r <= 1'b0;
            irq_r <= 1'b0;
            wake_r <= 1'b0;
            trig_q <= 1'b0;
        end else begin
            fault_n_d_r <= fault_n_s;
            flag_r <= flag_nxt;
            active_r <= active_nxt;
            pin_r <= pin_nxt;
            run_r <= run_nxt;
            buffer_load_r <= buffer_load_req && run_nxt &&
                             !second_control_reg_r[pflt_pkg::SC_LOCK_BIT];
            irq_r <= flag_nxt;
            wake_r <= flag_nxt && cpu_sleep;
            trig_q <= trig_post;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_ok) begin
            rdata_r <= pwrite ? 32'h0000_0000 : read_mux(paddr, status_word);
            pslverr <= !mapped;
        end
    end

    // Always ready: one access cycle
    assign pready = 1'b1;
    assign prdata = rdata_r;
    assign pin_out = pin_r;
    assign trigger_out = trig_q;
    assign fault_irq = irq_r;
    assign wake_req = wake_r;
    assign buffer_load = buffer_load_r;
    assign pwm_run = run_r;
endmodule // pflt_top

// ==== inc/pflt_pkg.sv ====
// Contract
// - Active-low fault input forces enabled outputs
// - One fault enable bit per pin pair
// - All enables clear: fault ignored by outputs
// - Fault flag independent of modulator outputs
// - Per-pin fault state: clear inactive, set active
// - Fault levels pass through pin polarity
// - Complementary pair: high side wins on fault
// - Latched: release needs input high, flag cleared
// - Flag cleared early: wait for input high
// - Cycle mode: hold only while input low; code holds until the next cycle boundary after input high
// - One mode bit selects latched or cycle
// - Lockout blocks duty and period transfers
// - Trigger when count equals compare value
// - Direction bit picks up or down phase
// - Direction ignored outside up/down modes
// - Trigger postscaler ratio one to sixteen
// - Compare write or reset clears postscaler
// - Fault low in sleep raises flag, wakes
// - Idle stop bit halts modulator in idle
// - Polarity bits set high/low active levels
package pflt_pkg;
    localparam logic [11:0] ADDR_FAULT_CTRL = 12'h000;
    localparam logic [11:0] ADDR_SECOND_CTRL = 12'h004;
    localparam logic [11:0] ADDR_TRIG_CMP = 12'h008;
    localparam logic [11:0] ADDR_TIME_CTRL = 12'h00c;
    localparam logic [11:0] ADDR_STATUS = 12'h010;
    localparam logic [11:0] ADDR_POLARITY = 12'h014;
    // Fault control fields
    localparam int FC_EN_LSB = 0;
    localparam int FC_MODE_BIT = 7;
    localparam int FC_OVR_LSB = 8;
    // Second control fields
    localparam int SC_LOCK_BIT = 0;
    localparam int SC_OPS_LSB = 8;
    // Trigger compare fields
    localparam int TC_DIR_BIT = 15;
    // Time control fields
    localparam int TM_IDLE_BIT = 13;
    // Status fields
    localparam int ST_FLAG_BIT = 0;
    localparam int ST_ACTIVE_BIT = 1;
    localparam int ST_PIN_BIT = 2;
    localparam logic [31:0] FAULT_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] SECOND_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] TRIG_CMP_RST = 32'h0000_0000;
    localparam logic [31:0] TIME_CTRL_RST = 32'h0000_0000;
    localparam logic [1:0] POLARITY_RST = 2'h3;
    localparam logic [3:0] POST_RST = 4'h0;

    typedef struct packed {
        logic [2:0] pair_en;
        logic latch_mode;
        logic [5:0] ovr_state;
    } pflt_fault_cfg_type;

    typedef struct packed {
        logic [5:0] pins;
    } pflt_pins_type;
endpackage

// ==== rtl/pflt_sync.sv ====
`timescale 1ns/1ps
module pflt_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic d,
    output logic q
);
    logic meta_r;
    logic q_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= 1'b1;
            q_r <= 1'b1;
        end else begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end
    assign q = q_r;
endmodule // pflt_sync

// ==== rtl/pflt_post.sv ====
`timescale 1ns/1ps
module pflt_post (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic event_in,
    input wire logic [3:0] ratio,
    output logic event_out
);
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic out_r;
    wire logic hit = event_in && (cnt_r == ratio);
    assign cnt_nxt = clear ? pflt_pkg::POST_RST : (hit ? pflt_pkg::POST_RST : cnt_r + 4'h1);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= pflt_pkg::POST_RST;
            out_r <= 1'b0;
        end else begin
            if (clear || event_in) begin
                cnt_r <= cnt_nxt;
            end
            out_r <= hit && !clear;
        end
    end
    assign event_out = out_r;
endmodule // pflt_post

// ==== test/pflt_chk.sv ====
`timescale 1ns/1ps
module pflt_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic fault_input_a_n,
    input wire logic [5:0] duty_pins,
    input wire logic cycle_boundary,
    input wire logic cpu_sleep,
    input wire logic cpu_idle,
    input wire logic buffer_load_req,
    input wire logic buffer_load,
    input wire logic pwm_run,
    input wire logic [5:0] pin_out,
    input wire logic fault_irq,
    input wire logic wake_req
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Flag clear is write-one, taken at the access edge
    wire clr = psel && penable && pwrite && paddr == pflt_pkg::ADDR_STATUS && pwdata[0];
    a_idle_run: assert property (!cpu_idle |=> pwm_run)
        else $error("run low out of idle");
    a_idle_halt: assert property (!pwm_run |-> $past(cpu_idle))
        else $error("halt without idle");
    a_load_gate: assert property (buffer_load |-> $past(buffer_load_req) && pwm_run)
        else $error("load without request");
    a_wake_sleep: assert property (wake_req == (fault_irq && $past(cpu_sleep)))
        else $error("wake mismatch");
    a_flag_sets: assert property ($fell(fault_input_a_n) |-> ##[1:6] fault_irq)
        else $error("flag not set");
    a_flag_holds: assert property (fault_irq && !clr |=> fault_irq)
        else $error("flag lost");
    a_flag_clears: assert property (fault_input_a_n [*5] ##0 clr |-> ##2 !fault_irq)
        else $error("flag not cleared");
    a_pins_normal: assert property ((fault_input_a_n && !fault_irq) [*8] ##0 cycle_boundary
        |-> ##2 pin_out == $past(duty_pins)) else $error("pins not released");
endmodule // pflt_chk

// ==== test/pflt_stage.sv ====
`timescale 1ns/1ps
module pflt_stage (
    input wire logic pclk,
    input wire logic fault_cmd,
    input wire logic trigger_out,
    output logic fault_input_a_n,
    output int trig_cnt
);
    // Pulled up unless the bench forces a fault
    assign fault_input_a_n = !fault_cmd;
    int cnt_r = 0;
    always @(posedge pclk) if (trigger_out === 1'b1) cnt_r <= cnt_r + 1;
    assign trig_cnt = cnt_r;
endmodule // pflt_stage

// ==== test/pflt_top_tb.sv ====
`timescale 1ns/1ps
module pflt_top_tb;
    logic pclk, presetn, psel, penable, pwrite, fcmd, count_down, updown_mode, cycle_boundary;
    logic cpu_sleep, cpu_idle, buffer_load_req, pready, pslverr, buffer_load, pwm_run;
    logic trigger_out, fault_irq, wake_req, fault_input_a_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, fc;
    logic [5:0] duty_pins, pin_out;
    logic [2:0] pair_complementary;
    logic [15:0] time_base_count, seed;
    logic [1:0] pl;
    int n_errors, cmp_count, tcnt, k, cyc;

    pflt_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .fault_input_a_n, .duty_pins, .pair_complementary, .time_base_count, .count_down, .updown_mode,
        .cycle_boundary, .cpu_sleep, .cpu_idle, .buffer_load_req, .buffer_load, .pwm_run, .pin_out,
        .trigger_out, .fault_irq, .wake_req);
    pflt_stage u_stage (.pclk, .fault_cmd(fcmd), .trigger_out, .fault_input_a_n, .trig_cnt(tcnt));

    function logic [15:0] lf(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function logic [5:0] xp(input logic a);
        logic [5:0] p;
        logic h;
        logic l;
        p = duty_pins;
        for (int g = 0; g < 3; g++) begin
            h = fc[9 + 2 * g];
            // High side wins a complementary pair
            l = fc[8 + 2 * g] && !(pair_complementary[g] && h);
            if (a && fc[g]) begin
                p[2 * g + 1] = h ? pl[1] : !pl[1];
                p[2 * g] = l ? pl[0] : !pl[0];
            end
        end
        return p;
    endfunction
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("[ERR] %s exp %h got %h", nm, e, g);
            n_errors++;
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task flt(input logic v);
        fcmd <= v;
        repeat (6) @(posedge pclk);
    endtask
    task bd;
        cycle_boundary <= 1'b1;
        @(posedge pclk);
        cycle_boundary <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    task pc(input logic a);
        chk("pins", {26'h0, xp(a)}, {26'h0, pin_out});
    endtask
    task ld(input logic e);
        buffer_load_req <= 1'b1;
        @(posedge pclk);
        buffer_load_req <= 1'b0;
        // Pulse stands one cycle: look at it mid-cycle
        @(negedge pclk);
        chk("load", {31'h0, e}, {31'h0, buffer_load});
        @(posedge pclk);
    endtask
    task tr(input int r, input logic u, input logic d, input int n);
        int b;
        time_base_count <= 16'h7;
        apb(1'b1, 12'h004, 32'(r) << 8);
        apb(1'b1, 12'h008, {16'h0, d, 15'h3});
        updown_mode <= u;
        b = tcnt;
        for (int s = 0; s < n; s++) begin
            count_down <= s[0];
            for (int c = 0; c < 8; c++) begin
                time_base_count <= 16'(c);
                @(posedge pclk);
            end
        end
        repeat (4) @(posedge pclk);
        chk("trig", 32'((u ? (d ? n / 2 : n - n / 2) : n) / (r + 1)), 32'(tcnt - b));
    endtask
    task finish_test;
        if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // Whole run needs about 740 cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc > 20000) begin
            n_errors++;
            finish_test;
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, fcmd, count_down, updown_mode} = 7'h0;
        {cycle_boundary, cpu_sleep, cpu_idle, buffer_load_req} = 4'h0;
        {paddr, pwdata, duty_pins, pair_complementary, time_base_count} = 69'h0;
        seed = 16'h5;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (k = 0; k < 7; k++) begin
            apb(1'b0, 12'(4 * k), 32'h0);
            chk("reg", k == 5 ? 32'h3 : 32'h0, rd);
            chk("slverr", {31'h0, k == 6}, {31'h0, pslverr});
        end
        for (k = 0; k < 5; k++) begin
            seed = lf(seed);
            fc = {18'h0, seed[13:8], 5'h0, (k == 0 ? 3'h0 : seed[2:0])};
            pl = seed[15:14];
            duty_pins <= seed[11:6];
            pair_complementary <= seed[7:5];
            apb(1'b1, 12'h000, fc);
            apb(1'b1, 12'h014, {30'h0, pl});
            flt(1'b1);
            pc(1'b1);
            chk("irq", 32'h1, {31'h0, fault_irq});
            apb(1'b1, 12'h010, 32'h1);
            flt(1'b0);
            pc(1'b1);
            bd;
            pc(1'b0);
        end
        fc = 32'h3f87;
        cpu_sleep <= 1'b1;
        apb(1'b1, 12'h000, fc);
        flt(1'b1);
        chk("wake", 32'h1, {31'h0, wake_req});
        flt(1'b0);
        bd;
        pc(1'b1);
        apb(1'b1, 12'h010, 32'h1);
        bd;
        pc(1'b0);
        flt(1'b1);
        apb(1'b1, 12'h010, 32'h1);
        bd;
        pc(1'b1);
        flt(1'b0);
        bd;
        pc(1'b0);
        cpu_sleep <= 1'b0;
        apb(1'b1, 12'h004, 32'h1);
        ld(1'b0);
        apb(1'b1, 12'h004, 32'h0);
        ld(1'b1);
        for (k = 0; k < 2; k++) begin
            apb(1'b1, 12'h00c, 32'(k) << 13);
            cpu_idle <= 1'b1;
            @(posedge pclk);
            ld(k == 0);
            chk("run", 32'(k == 0), {31'h0, pwm_run});
            cpu_idle <= 1'b0;
            @(posedge pclk);
        end
        tr(2, 1'b1, 1'b1, 12);
        tr(0, 1'b0, 1'b1, 5);
        tr(15, 1'b1, 1'b0, 32);
        tr(2, 1'b1, 1'b0, 4);
        tr(2, 1'b1, 1'b0, 4);
        finish_test;
    end
endmodule // pflt_top_tb

bind pflt_top pflt_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .fault_input_a_n,
    .duty_pins, .cycle_boundary, .cpu_sleep, .cpu_idle, .buffer_load_req, .buffer_load, .pwm_run, .pin_out,
    .fault_irq, .wake_req);
